// ### core/chgms_core.sv
// Charge controller core: mode decode, master reset, sequencing, removal
// Summary of operation
// [RQ1] Both aux pins low: system test mode
// [RQ2] Low/high: indefinite C/40 maintenance, no fast
// [RQ3] Open/low: discharge to 1V/cell, then stop
// [RQ4] High/low: discharge to 1V/cell, then charge
// [RQ5] High/open: timed C/10 topping, then maintenance
// [RQ6] Both high: total charge capped at 10h
// [RQ7] Reset accepted only after low over 700ms
// [RQ8] Held in reset while reset input low
// [RQ9] Mode, rate, timer, test cleared by reset
// [RQ10] Power-up performs a reset by itself
// [RQ11] Timing counted in 1 MHz ticks
// [RQ12] External clock duty within 10% to 60%
// [RQ13] Compare battery to reference only while charging
// [RQ14] Battery above reference means removed: poll
// [RQ15] Reference above 2.3V blocks fast charge
// [RQ16] Reference above 4V: shutdown until reset
// [RQ17] Polling emits periodic probe charge pulses
// [RQ18] Charge request high asks for current
// [RQ19] Select pins decode low, open, high
// [RQ20] Aux pins latched at reset end
// [RQ21] Both aux open: default fast charge
`timescale 1ns/1ns
module chgms_core
  import chgms_pkg::*;
#(
  parameter int unsigned RESET_TICKS = T_RESET_MS * TICKS_PER_MS,
  parameter int unsigned POLL_PER_TICKS = T_POLL_PER_MS * TICKS_PER_MS,
  parameter int unsigned POLL_W_TICKS = T_POLL_W_MS * TICKS_PER_MS,
  parameter int unsigned CHG_PER_TICKS = T_CHG_CYCLE_MS * TICKS_PER_MS,
  parameter int unsigned CHG_W_TICKS = T_CHG_W_MS * TICKS_PER_MS,
  parameter int unsigned DIS_PER_TICKS = T_DIS_PER_MS * TICKS_PER_MS,
  parameter int unsigned DIS_W_TICKS = T_DIS_W_MS * TICKS_PER_MS,
  parameter int unsigned MAINT_PER_TICKS = T_MAINT_PER_S * TICKS_PER_S,
  parameter int unsigned TOPUP_PER_TICKS = T_TOPUP_PER_S * TICKS_PER_S,
  parameter logic [35:0] TEN_HOUR_TICKS =
    36'(64'(T_TEN_HOUR_H) * 64'(SEC_PER_H) * 64'(TICKS_PER_S)),
  parameter logic [35:0] COND_TICKS =
    36'(64'(T_COND_H) * 64'(SEC_PER_H) * 64'(TICKS_PER_S))
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Pins, asynchronous
  input wire logic master_reset_low_i,
  input chgms_tri_type aux_mode_sel_a_i,
  input chgms_tri_type aux_mode_sel_b_i,
  input chgms_tri_type rate_sel_a_i,
  input chgms_tri_type rate_sel_b_i,
  input chgms_cmp_type cmp_i,
  // Termination logic, same clock
  input wire logic fast_done_i,
  // Outputs
  output logic charge_request_out_o,
  output logic discharge_out_o,
  output logic polling_indicator_low_o,
  output chgms_status_type status_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  // ****************************************************************
  // Input synchronisation
  // ****************************************************************
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] syn;
  chgms_tri_type aux_a_s, aux_b_s, rate_a_s, rate_b_s;
  chgms_cmp_type cmp_s;
  logic mrl_s;

  assign raw = {master_reset_low_i, aux_mode_sel_a_i, aux_mode_sel_b_i,
                rate_sel_a_i, rate_sel_b_i, cmp_i};
  assign {mrl_s, aux_a_s, aux_b_s, rate_a_s, rate_b_s, cmp_s} = syn;

  chgms_sync #(.W(SYNC_W)) u_sync (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .async_i(raw), .sync_o(syn));

  // Floating mid-supply shows neither threshold, so reads open
  function automatic chgms_level_type lvl(input chgms_tri_type p);
    if (p.hi && !p.lo) return LVL_HIGH; // [RQ19]
    if (p.lo && !p.hi) return LVL_LOW; // [RQ19]
    return LVL_OPEN; // [RQ19]
  endfunction

  function automatic chgms_aux_type aux_decode(input chgms_level_type a,
                                               input chgms_level_type b);
    case ({a, b})
      {LVL_LOW, LVL_LOW}: return AUX_TEST; // [RQ1]
      {LVL_LOW, LVL_HIGH}: return AUX_DIRECT; // [RQ2]
      {LVL_OPEN, LVL_LOW}: return AUX_DISONLY; // [RQ3]
      {LVL_HIGH, LVL_LOW}: return AUX_DISCHG; // [RQ4]
      {LVL_HIGH, LVL_OPEN}: return AUX_COND; // [RQ5]
      {LVL_HIGH, LVL_HIGH}: return AUX_TENHR; // [RQ6]
      default: return AUX_FAST; // [RQ21]
    endcase
  endfunction

  // ****************************************************************
  // Time base and master reset filter
  // ****************************************************************
  logic [TOP_DIV_W-1:0] div_r, div_nxt;
  logic [LOW_CNT_W-1:0] low_cnt_r, low_cnt_nxt;
  logic tick;
  logic hold_req;

  assign tick = (div_r == TOP_DIV_W'(CYC_PER_TICK - 1)); // [RQ11]
  assign hold_req = (low_cnt_r > LOW_CNT_W'(RESET_TICKS)); // [RQ7]

  always_comb begin
    div_nxt = tick ? '0 : div_r + 1'b1;
    low_cnt_nxt = low_cnt_r;
    if (mrl_s) begin
      low_cnt_nxt = '0;
    end else if (tick && !hold_req) begin
      low_cnt_nxt = low_cnt_r + 1'b1; // [RQ7]
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_r <= '0;
      low_cnt_r <= '0;
    end else begin
      div_r <= div_nxt;
      low_cnt_r <= low_cnt_nxt;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  chgms_state_type state_r, state_nxt;
  chgms_aux_type aux_r, aux_nxt;
  chgms_level_type rate_a_r, rate_a_nxt, rate_b_r, rate_b_nxt;
  logic [31:0] ph_r, ph_nxt;
  logic [SES_W-1:0] ses_r, ses_nxt;
  logic chg_r, chg_nxt, dis_r, dis_nxt, pol_n_r, pol_n_nxt;
  logic [31:0] per_c, wid_c, per_n, wid_n;
  logic sample;
  logic charging;

  function automatic void pulse_shape(input chgms_state_type s,
                                      output logic [31:0] per,
                                      output logic [31:0] wid);
    per = CHG_PER_TICKS;
    wid = CHG_W_TICKS;
    case (s)
      ST_POLL: begin
        per = POLL_PER_TICKS;
        wid = POLL_W_TICKS;
      end
      ST_DISCH: begin
        per = DIS_PER_TICKS;
        wid = DIS_W_TICKS;
      end
      ST_MAINT: per = MAINT_PER_TICKS;
      ST_TOPUP: per = TOPUP_PER_TICKS;
      default: per = CHG_PER_TICKS;
    endcase
  endfunction

  // Start state after polling; fast charge is entered only from ST_WAIT
  function automatic chgms_state_type start_of(input chgms_aux_type m);
    case (m)
      AUX_DIRECT: return ST_MAINT; // [RQ2]
      AUX_DISONLY, AUX_DISCHG: return ST_DISCH; // [RQ3] [RQ4]
      AUX_COND: return ST_TOPUP; // [RQ5]
      default: return ST_WAIT;
    endcase
  endfunction

  assign charging = (state_r == ST_FAST) || (state_r == ST_TOPUP) ||
                    (state_r == ST_MAINT);
  // Sample at the last tick of a pulse, once the source has settled
  assign sample = tick && chg_r && (ph_r == wid_c - 1); // [RQ13]

  always_comb begin
    pulse_shape(state_r, per_c, wid_c);
    state_nxt = state_r;
    aux_nxt = aux_r;
    rate_a_nxt = rate_a_r;
    rate_b_nxt = rate_b_r;
    ses_nxt = ses_r;
    if (charging && tick) begin
      ses_nxt = ses_r + 1'b1;
    end
    case (state_r)
      ST_HOLD: begin
        ses_nxt = '0; // [RQ9]
        if (mrl_s && !hold_req) begin // [RQ8]
          aux_nxt = aux_decode(lvl(aux_a_s), lvl(aux_b_s)); // [RQ20]
          rate_a_nxt = lvl(rate_a_s); // [RQ9]
          rate_b_nxt = lvl(rate_b_s);
          state_nxt = (aux_decode(lvl(aux_a_s), lvl(aux_b_s)) == AUX_TEST)
                      ? ST_TEST : ST_POLL; // [RQ1]
        end
      end
      ST_POLL: begin
        if (sample && !cmp_s.vin_above_ref) begin // [RQ17]
          state_nxt = start_of(aux_r);
        end
      end
      ST_WAIT: begin
        if (!cmp_s.ref_above_fast_lim) begin // [RQ15]
          state_nxt = ST_FAST;
        end
      end
      ST_DISCH: begin
        if (cmp_s.cell_at_floor) begin
          state_nxt = (aux_r == AUX_DISONLY) ? ST_STOP : ST_WAIT; // [RQ3][RQ4]
        end
      end
      ST_FAST: begin
        if (fast_done_i) begin
          state_nxt = ST_MAINT;
        end
      end
      ST_TOPUP: begin
        if (ses_r >= COND_TICKS) begin
          state_nxt = ST_MAINT; // [RQ5]
        end
      end
      ST_MAINT, ST_TEST, ST_STOP, ST_SHUT: state_nxt = state_r;
      default: state_nxt = ST_HOLD;
    endcase
    if (charging && sample && cmp_s.vin_above_ref) begin
      state_nxt = ST_POLL; // [RQ14]
    end
    if (charging && aux_r == AUX_TENHR && ses_r >= TEN_HOUR_TICKS) begin
      state_nxt = ST_STOP; // [RQ6]
    end
    if (state_r != ST_HOLD && cmp_s.ref_above_shut) begin
      state_nxt = ST_SHUT; // [RQ16]
    end
    if (hold_req) begin
      state_nxt = ST_HOLD; // [RQ7] [RQ8] [RQ9]
    end
    if (state_nxt != state_r) begin
      ph_nxt = '0;
    end else if (tick) begin
      ph_nxt = (ph_r >= per_c - 1) ? '0 : ph_r + 1'b1;
    end else begin
      ph_nxt = ph_r;
    end
    pulse_shape(state_nxt, per_n, wid_n);
    chg_nxt = ((state_nxt == ST_POLL) || (state_nxt == ST_FAST) ||
               (state_nxt == ST_TOPUP) || (state_nxt == ST_MAINT) ||
               (state_nxt == ST_TEST)) && (ph_nxt < wid_n); // [RQ17] [RQ18]
    dis_nxt = (state_nxt == ST_DISCH) && (ph_nxt < wid_n);
    pol_n_nxt = (state_nxt != ST_POLL);
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= ST_HOLD; // [RQ10]
      aux_r <= AUX_FAST;
      rate_a_r <= LVL_OPEN;
      rate_b_r <= LVL_OPEN;
      ph_r <= '0;
      ses_r <= '0;
      chg_r <= 1'b0;
      dis_r <= 1'b0;
      pol_n_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      aux_r <= aux_nxt;
      rate_a_r <= rate_a_nxt;
      rate_b_r <= rate_b_nxt;
      ph_r <= ph_nxt;
      ses_r <= ses_nxt;
      chg_r <= chg_nxt;
      dis_r <= dis_nxt;
      pol_n_r <= pol_n_nxt;
    end
  end

  assign charge_request_out_o = chg_r;
  assign discharge_out_o = dis_r;
  assign polling_indicator_low_o = pol_n_r;
  assign status_o = '{state: state_r, aux_mode: aux_r,
                      rate_a: rate_a_r, rate_b: rate_b_r};

  // ****************************************************************
  // Checks
  // ****************************************************************
  tick_period_a: assert property (tick |=> !tick [*8]) // [RQ11]
    else $error("tick spacing too short");
  reset_filter_a: assert property ((state_r != ST_HOLD) ##1 // [RQ7]
    (state_r == ST_HOLD) |-> $past(hold_req))
    else $error("reset taken before filter expired");
  hold_keep_a: assert property ((state_r == ST_HOLD) && !mrl_s |=> // [RQ8]
    (state_r == ST_HOLD)) else $error("left reset while input low");
  mode_latch_a: assert property ((state_r != ST_HOLD) |=> // [RQ20]
    $stable(aux_r) && $stable(rate_a_r) && $stable(rate_b_r))
    else $error("mode changed outside reset");
  test_entry_a: assert property ((state_r == ST_TEST) |-> // [RQ1]
    (aux_r == AUX_TEST)) else $error("test state without test mode");
  remove_gate_a: assert property (charging && sample && // [RQ14]
    cmp_s.vin_above_ref && !hold_req && !cmp_s.ref_above_shut &&
    !(aux_r == AUX_TENHR && ses_r >= TEN_HOUR_TICKS) |=>
    (state_r == ST_POLL) && !pol_n_r)
    else $error("battery removal not acted on");
  fast_block_a: assert property ($rose(state_r == ST_FAST) |-> // [RQ15]
    !$past(cmp_s.ref_above_fast_lim))
    else $error("fast charge began with reference high");
  shut_stay_a: assert property ((state_r == ST_SHUT) && !hold_req // [RQ16]
    |=> (state_r == ST_SHUT) && !chg_r)
    else $error("left shutdown without reset");
  ten_hour_a: assert property ((state_r == ST_STOP) |=> // [RQ6]
    !chg_r && !dis_r) else $error("output active after stop");
  direct_maint_a: assert property ((aux_r == AUX_DIRECT) && // [RQ2]
    (state_r != ST_HOLD) |-> (state_r != ST_FAST))
    else $error("fast charge in direct maintenance");

endmodule

// ### core/chgms_sync.sv
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module chgms_sync
  import chgms_pkg::*;
#(
  parameter int unsigned W = SYNC_W
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second one
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          meta_r[gi] <= 1'b0;
          sync_o[gi] <= 1'b0;
        end else begin
          meta_r[gi] <= async_i[gi];
          sync_o[gi] <= meta_r[gi];
        end
      end
    end
  endgenerate

endmodule

// ### shared/chgms_pkg.sv
// Constants, enumerations and carrier types of the charge mode/reset core
package chgms_pkg;

  // ****************************************************************
  // Time base
  // ****************************************************************
  localparam int unsigned CORE_CLK_HZ = 25_000_000;
  localparam int unsigned TICK_HZ = 1_000_000;
  localparam int unsigned CYC_PER_TICK = CORE_CLK_HZ / TICK_HZ;
  localparam int unsigned TICKS_PER_MS = TICK_HZ / 1000;
  localparam int unsigned TICKS_PER_S = TICK_HZ;

  // ****************************************************************
  // Durations, in their own units
  // ****************************************************************
  localparam int unsigned T_RESET_MS = 700;
  localparam int unsigned T_POLL_PER_MS = 624;
  localparam int unsigned T_POLL_W_MS = 100;
  localparam int unsigned T_CHG_CYCLE_MS = 1077;
  localparam int unsigned T_CHG_W_MS = 1048;
  localparam int unsigned T_DIS_PER_MS = 1050;
  localparam int unsigned T_DIS_W_MS = 400;
  localparam int unsigned T_MAINT_PER_S = 40;
  localparam int unsigned T_TOPUP_PER_S = 10;
  localparam int unsigned T_TEN_HOUR_H = 10;
  localparam int unsigned T_COND_H = 10;
  localparam int unsigned SEC_PER_H = 3600;

  // ****************************************************************
  // Synchroniser and counter widths
  // ****************************************************************
  localparam int unsigned SYNC_W = 13;
  localparam int unsigned TOP_DIV_W = 5;
  localparam int unsigned LOW_CNT_W = 21;
  localparam int unsigned SES_W = 36;

  // ****************************************************************
  // Enumerations
  // ****************************************************************
  typedef enum logic [1:0] {
    LVL_LOW  = 2'b00,
    LVL_OPEN = 2'b01,
    LVL_HIGH = 2'b10
  } chgms_level_type;

  typedef enum logic [2:0] {
    AUX_FAST    = 3'b000,
    AUX_TEST    = 3'b001,
    AUX_DIRECT  = 3'b010,
    AUX_DISONLY = 3'b011,
    AUX_DISCHG  = 3'b100,
    AUX_COND    = 3'b101,
    AUX_TENHR   = 3'b110
  } chgms_aux_type;

  typedef enum logic [3:0] {
    ST_HOLD  = 4'b0000,
    ST_POLL  = 4'b0001,
    ST_WAIT  = 4'b0010,
    ST_DISCH = 4'b0011,
    ST_FAST  = 4'b0100,
    ST_TOPUP = 4'b0101,
    ST_MAINT = 4'b0110,
    ST_TEST  = 4'b0111,
    ST_STOP  = 4'b1000,
    ST_SHUT  = 4'b1001
  } chgms_state_type;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic hi;
    logic lo;
  } chgms_tri_type;

  typedef struct packed {
    logic vin_above_ref;
    logic ref_above_fast_lim;
    logic ref_above_shut;
    logic cell_at_floor;
  } chgms_cmp_type;

  typedef struct packed {
    chgms_state_type state;
    chgms_aux_type aux_mode;
    chgms_level_type rate_a;
    chgms_level_type rate_b;
  } chgms_status_type;

endpackage

// ### sim/chgms_batt_model.sv
// Battery, charge source and discharge load facing the core
`timescale 1ns/1ns
module chgms_batt_model
  import chgms_pkg::*;
#(
  parameter int unsigned FLOOR_PULSES = 2
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // From the core
  input wire logic charge_request_out_i,
  input wire logic discharge_out_i,
  // Scenario controls
  input wire logic present_i,
  input wire logic ref_fast_lim_i,
  input wire logic ref_shut_i,
  // To the core
  output chgms_cmp_type cmp_o
);
  logic dis_d_r;
  logic [3:0] dis_cnt_r;

  // Discharge pulses drain the cell; any charge pulse refills it
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dis_d_r <= 1'b0;
      dis_cnt_r <= 4'h0;
    end else begin
      dis_d_r <= discharge_out_i;
      if (charge_request_out_i) begin
        dis_cnt_r <= 4'h0;
      end else if (discharge_out_i && !dis_d_r && dis_cnt_r != 4'hf) begin
        dis_cnt_r <= dis_cnt_r + 4'h1;
      end
    end
  end

  // Empty terminals rise above the reference only while current flows
  assign cmp_o.vin_above_ref = charge_request_out_i && !present_i;
  assign cmp_o.ref_above_fast_lim = ref_fast_lim_i;
  assign cmp_o.ref_above_shut = ref_shut_i;
  assign cmp_o.cell_at_floor = present_i && (dis_cnt_r >= 4'(FLOOR_PULSES));
endmodule

// ### sim/test_charger_mode_select_reset.sv
// Self-checking bench for the charge mode and reset core
`timescale 1ns/1ns
module test_charger_mode_select_reset;
  import chgms_pkg::*;
  localparam int unsigned RST_T = 20;
  localparam int unsigned POLL_PER = 40;
  localparam int unsigned POLL_W = 8;
  localparam int unsigned CHG_PER = 30;
  localparam int unsigned TK = CYC_PER_TICK;
  localparam int unsigned CHG_W = 25;
  localparam int unsigned DIS_PER = 30;
  localparam int unsigned DIS_W = 10;
  localparam logic [35:0] TEN_HR = 36'h0000000c8;
  localparam logic [35:0] COND_T = 36'h000000096;
  logic core_clk_i;
  logic nrst_i;
  logic mrst_low;
  logic fast_done;
  logic charge_request_out;
  logic dis;
  logic pol_low;
  logic present;
  logic lim;
  logic shut;
  chgms_tri_type aux_a;
  chgms_tri_type aux_b;
  chgms_tri_type rate_a;
  chgms_tri_type rate_b;
  chgms_cmp_type cmp;
  chgms_status_type status;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;

  // Scaled timing; maintenance and topping periods keep their defaults
  chgms_core #(.RESET_TICKS(RST_T), .POLL_PER_TICKS(POLL_PER),
    .POLL_W_TICKS(POLL_W), .CHG_PER_TICKS(CHG_PER), .CHG_W_TICKS(CHG_W),
    .DIS_PER_TICKS(DIS_PER), .DIS_W_TICKS(DIS_W),
    .TEN_HOUR_TICKS(TEN_HR), .COND_TICKS(COND_T)) uut (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .master_reset_low_i(mrst_low), .aux_mode_sel_a_i(aux_a),
    .aux_mode_sel_b_i(aux_b), .rate_sel_a_i(rate_a), .rate_sel_b_i(rate_b),
    .cmp_i(cmp), .fast_done_i(fast_done), .charge_request_out_o(charge_request_out),
    .discharge_out_o(dis), .polling_indicator_low_o(pol_low),
    .status_o(status));

  chgms_batt_model model (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .charge_request_out_i(charge_request_out), .discharge_out_i(dis), .present_i(present),
    .ref_fast_lim_i(lim), .ref_shut_i(shut), .cmp_o(cmp));

  // Even duty, well inside the accepted range
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic stop_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 100000) begin
      fails++;
      stop_test();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk_st(input chgms_state_type st);
    chk(16'(status.state), 16'(st));
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask

  // Open pins sit between both thresholds
  function automatic chgms_tri_type pin(input chgms_level_type l);
    return '{hi: l == LVL_HIGH, lo: l == LVL_LOW};
  endfunction

  task automatic wait_state(input chgms_state_type st, input int lim_n);
    int n;
    n = 0;
    while (status.state !== st && n < lim_n) begin
      cyc(1);
      n++;
    end
  endtask

  task automatic wait_chg(input logic v, output int n);
    n = 0;
    while (charge_request_out !== v && n < 3000) begin
      cyc(1);
      n++;
    end
  endtask

  task automatic mreset(input int ticks);
    mrst_low = 1'b0;
    cyc(ticks * TK);
    mrst_low = 1'b1;
    cyc(5);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic power_up();
    wait_state(ST_POLL, 10);
    chk_st(ST_POLL);
    chk(16'(pol_low), 16'h0000);
    chk(16'(charge_request_out), 16'h0001);
    wait_state(ST_FAST, 3000);
    chk_st(ST_FAST);
  endtask

  task automatic mode_table();
    chgms_level_type la [7] = '{LVL_LOW, LVL_LOW, LVL_OPEN, LVL_OPEN,
      LVL_HIGH, LVL_HIGH, LVL_HIGH};
    chgms_level_type lb [7] = '{LVL_LOW, LVL_HIGH, LVL_OPEN, LVL_LOW,
      LVL_LOW, LVL_OPEN, LVL_HIGH};
    chgms_aux_type am [7] = '{AUX_TEST, AUX_DIRECT, AUX_FAST, AUX_DISONLY,
      AUX_DISCHG, AUX_COND, AUX_TENHR};
    chgms_state_type s0 [7] = '{ST_TEST, ST_MAINT, ST_FAST, ST_DISCH,
      ST_DISCH, ST_TOPUP, ST_FAST};
    chgms_state_type s1 [7] = '{ST_TEST, ST_MAINT, ST_MAINT, ST_STOP,
      ST_FAST, ST_MAINT, ST_STOP};
    for (int i = 0; i < 7; i++) begin
      aux_a = pin(la[i]);
      aux_b = pin(lb[i]);
      rate_a = pin(lb[i]);
      rate_b = pin(la[i]);
      mrst_low = 1'b0;
      cyc((RST_T + 3) * TK);
      chk_st(ST_HOLD);
      chk(16'(charge_request_out), 16'h0000);
      mrst_low = 1'b1;
      cyc(5);
      chk(16'(status.aux_mode), 16'(am[i]));
      chk(16'({status.rate_a, status.rate_b}), 16'({lb[i], la[i]}));
      wait_state(s0[i], 3000);
      chk_st(s0[i]);
      chk(16'(dis), 16'(s0[i] == ST_DISCH));
      if (am[i] == AUX_FAST) begin
        fast_done = 1'b1;
        cyc(1);
        fast_done = 1'b0;
      end
      wait_state(s1[i], 9000);
      chk_st(s1[i]);
    end
    // Latched at reset end: later pin moves must not reach the mode
    aux_a = pin(LVL_LOW);
    aux_b = pin(LVL_LOW);
    cyc(100);
    chk(16'(status.aux_mode), 16'(AUX_TENHR));
    chk_st(ST_STOP);
  endtask

  task automatic removal();
    int n;
    int hi;
    int lo;
    aux_a = pin(LVL_OPEN);
    aux_b = pin(LVL_OPEN);
    mreset(RST_T + 3);
    wait_state(ST_FAST, 3000);
    present = 1'b0;
    wait_state(ST_POLL, CHG_PER * TK + 100);
    chk_st(ST_POLL);
    chk(16'(pol_low), 16'h0000);
    wait_chg(1'b0, n);
    wait_chg(1'b1, n);
    wait_chg(1'b0, hi);
    wait_chg(1'b1, lo);
    chk(16'(hi), 16'(POLL_W * TK));
    chk(16'(hi + lo), 16'(POLL_PER * TK));
    present = 1'b1;
    wait_state(ST_FAST, 3000);
    chk_st(ST_FAST);
    chk(16'(pol_low), 16'h0001);
    mreset(RST_T / 2);
    chk_st(ST_FAST);
  endtask

  task automatic ref_limits();
    lim = 1'b1;
    mreset(RST_T + 3);
    wait_state(ST_WAIT, 3000);
    cyc(CHG_PER * TK);
    chk_st(ST_WAIT);
    lim = 1'b0;
    wait_state(ST_FAST, 200);
    chk_st(ST_FAST);
    shut = 1'b1;
    wait_state(ST_SHUT, 20);
    chk_st(ST_SHUT);
    shut = 1'b0;
    cyc(100);
    chk_st(ST_SHUT);
    chk(16'(charge_request_out), 16'h0000);
    mreset(RST_T + 3);
    wait_state(ST_FAST, 3000);
    chk_st(ST_FAST);
  endtask

  initial begin
    nrst_i = 1'b0;
    mrst_low = 1'b1;
    fast_done = 1'b0;
    present = 1'b1;
    lim = 1'b0;
    shut = 1'b0;
    aux_a = pin(LVL_OPEN);
    aux_b = pin(LVL_OPEN);
    rate_a = pin(LVL_OPEN);
    rate_b = pin(LVL_OPEN);
    cyc(12);
    nrst_i = 1'b1;
    power_up();
    mode_table();
    removal();
    ref_limits();
    stop_test();
  end
endmodule
